// file: hdl/arsp_defs.vh
// Constants for the result serial port: widths and master clock timing.
// Assumes a 100 MHz system clock and a master clock tick from a divider.
`ifndef ARSP_DEFS_VH
`define ARSP_DEFS_VH
`define ARSP_WORD_BITS      20
`define ARSP_MCLK_DIV       3050
`define ARSP_CS_ACCESS_MCLK 2
`define ARSP_DR_ACCESS_MCLK 3
`define ARSP_DR_BLIND_MCLK  2'h2
`endif

// file: hdl/arsp_sync.v
// Two-flip-flop synchroniser for one asynchronous level.
// Assumes the input is from outside the i_clock domain.
`default_nettype none
module arsp_sync (
  // Clock and reset
  input  wire i_clock,
  input  wire i_arst_n,
  // Level in and out
  input  wire i_async,
  output wire o_sync
);
  reg stage1;
  reg stage2;
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
    end else begin
      stage1 <= i_async;
      stage2 <= stage1;
    end
  end
  assign o_sync = stage2;
endmodule // arsp_sync
`default_nettype wire

// file: hdl/arsp_port.v
// Result serial port: shifts a finished conversion word, taken only while idle, out MSB first.
// Assumes chip select, mode and host serial clock arrive asynchronously
// and that the converter hands a word with a one-cycle valid pulse.
`default_nettype none
`include "arsp_defs.vh"
module arsp_port #(
  parameter WORD_BITS = `ARSP_WORD_BITS,
  parameter MCLK_DIV  = `ARSP_MCLK_DIV
) (
  // Clock and reset
  input  wire                 i_clock,
  input  wire                 i_arst_n,
  // Converter side
  input  wire                 i_result_valid,
  input  wire [WORD_BITS-1:0] i_result_word,
  // Pins
  input  wire                 i_serial_mode_select,
  input  wire                 i_chip_select_n,
  input  wire                 i_serial_clock_in,
  output wire                 o_result_ready_n,
  output reg                  o_serial_result_out,
  output reg                  o_serial_result_oe,
  output reg                  o_serial_clock_out,
  output reg                  o_serial_clock_oe
);
  localparam ST_IDLE  = 3'd0;
  localparam ST_WAIT  = 3'd1;
  localparam ST_LEAD  = 3'd2;
  localparam ST_HIGH  = 3'd3;
  localparam ST_LOW   = 3'd4;
  localparam ST_TAIL  = 3'd5;
  localparam ST_EXT   = 3'd6;
  localparam CW = 5;

  wire mode_self;
  wire cs_n;
  wire sclk_in;
  reg  [11:0] div_count;
  reg  mclk_tick;
  reg  [WORD_BITS-1:0] shift;
  reg  [CW-1:0] bits_left;
  reg  [1:0] wait_count;
  reg  [2:0] state;
  reg  ready_n;
  reg  [1:0] blind_count;
  reg  sclk_prev;
  reg  ext_armed;
  reg  cs_prev;
  wire sclk_rise;
  wire sclk_fall;
  wire cs_act;

  arsp_sync u_mode (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_async(i_serial_mode_select), .o_sync(mode_self));
  arsp_sync u_cs (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_async(~i_chip_select_n), .o_sync(cs_act));
  arsp_sync u_sck (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_async(i_serial_clock_in), .o_sync(sclk_in));
  assign cs_n      = ~cs_act;
  assign sclk_rise = sclk_in & ~sclk_prev;
  assign sclk_fall = ~sclk_in & sclk_prev;
  assign o_result_ready_n = ready_n;

  ////////////////////////////////////////////////////////////////////////
  // Helpers. The word register moves the same way in both modes.
  function [WORD_BITS-1:0] shift_up;
    input [WORD_BITS-1:0] word;
    begin
      shift_up = {word[WORD_BITS-2:0], 1'b0};
    end
  endfunction

  // Bit counts are narrower than an integer, so the cut is made here.
  function [CW-1:0] to_count;
    input integer n;
    begin
      to_count = n[CW-1:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Master clock tick divider.
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_count <= 12'h000;
      mclk_tick <= 1'b0;
    end else if (div_count == MCLK_DIV - 1) begin
      div_count <= 12'h000;
      mclk_tick <= 1'b1;
    end else begin
      div_count <= div_count + 12'h001;
      mclk_tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shift engine. Outputs are registered so pins never glitch.
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state               <= ST_IDLE;
      shift               <= {WORD_BITS{1'b0}};
      bits_left           <= {CW{1'b0}};
      wait_count          <= 2'h0;
      ready_n             <= 1'b1;
      blind_count         <= 2'h0;
      sclk_prev           <= 1'b0;
      ext_armed           <= 1'b0;
      cs_prev             <= 1'b1;
      o_serial_result_out <= 1'b0;
      o_serial_result_oe  <= 1'b0;
      o_serial_clock_out  <= 1'b0;
      o_serial_clock_oe   <= 1'b0;
    end else begin
      sclk_prev <= sclk_in;
      cs_prev   <= cs_n;
      if (mclk_tick && blind_count != 2'h0)
        blind_count <= blind_count - 2'h1;
      if (i_result_valid && state == ST_IDLE) begin
        // Ready goes high for two master clocks, then falls with new word.
        shift       <= i_result_word;
        bits_left   <= to_count(WORD_BITS);
        ready_n     <= 1'b1;
        blind_count <= `ARSP_DR_BLIND_MCLK;
        wait_count  <= 2'h0;
      end else if (ready_n && state == ST_IDLE && bits_left != 0
                   && blind_count == 2'h0) begin
        ready_n <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          // Select held through the ready-high gap waits; shifting starts once ready falls.
          if (!cs_n && !ready_n && bits_left != 0 &&
              blind_count == 2'h0) begin
            wait_count <= 2'h0;
            state      <= mode_self ? ST_WAIT : ST_EXT;
            ext_armed  <= 1'b0;
          end
        end
        ST_WAIT: begin
          if (cs_n) begin
            state <= ST_IDLE;
          end else if (mclk_tick) begin
            // One tick after select: fits both access limits.
            o_serial_result_out <= shift[WORD_BITS-1];
            o_serial_result_oe  <= 1'b1;
            o_serial_clock_oe   <= 1'b1;
            state               <= ST_LEAD;
          end
        end
        ST_LEAD: if (mclk_tick) begin
          o_serial_clock_out <= 1'b1;
          bits_left          <= bits_left - 1'b1;
          state              <= ST_HIGH;
        end
        ST_HIGH: if (mclk_tick) begin
          o_serial_clock_out <= 1'b0;
          if (bits_left == 0) begin
            state <= ST_TAIL;
          end else if (cs_n) begin
            state <= ST_TAIL;
          end else begin
            shift               <= shift_up(shift);
            o_serial_result_out <= shift[WORD_BITS-2];
            state               <= ST_LOW;
          end
        end
        ST_LOW: if (mclk_tick) begin
          o_serial_clock_out <= 1'b1;
          bits_left          <= bits_left - 1'b1;
          state              <= ST_HIGH;
        end
        ST_TAIL: begin
          // Float one master clock after the last rising edge.
          o_serial_result_oe <= 1'b0;
          o_serial_clock_oe  <= 1'b0;
          ready_n            <= 1'b1;
          // A self-clocked word cut short by select is not offered again; the host
          // has to wait for the next result instead.
          bits_left          <= {CW{1'b0}};
          state <= ST_IDLE;
        end
        ST_EXT: begin
          if (cs_n) begin
            // Release at once; no bit is mid-flight between host edges.
            o_serial_result_oe <= 1'b0;
            state              <= ST_IDLE;
          end else begin
            o_serial_result_oe  <= 1'b1;
            if (!ext_armed) o_serial_result_out <= shift[WORD_BITS-1];
            if (sclk_rise) ext_armed <= 1'b1;
            if (sclk_fall && ext_armed) begin
              shift     <= shift_up(shift);
              bits_left <= bits_left - 1'b1;
              o_serial_result_out <= shift[WORD_BITS-2];
              if (bits_left == 1) begin
                o_serial_result_oe <= 1'b0;
                ready_n            <= 1'b1;
                state              <= ST_IDLE;
              end
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // arsp_port
`default_nettype wire

// file: dv/arsp_port_monitor.sv
// Checker on the result serial port pins.
// Assumes it is bound into arsp_port and sees only its ports.
`default_nettype none
module arsp_port_monitor #(parameter MCLK_DIV = 4, WORD_BITS = 20) (
  input wire logic i_clock, i_arst_n, i_result_valid,
  input wire logic [WORD_BITS-1:0] i_result_word,
  input wire logic i_serial_mode_select, i_chip_select_n, i_serial_clock_in,
  input wire logic o_result_ready_n, o_serial_result_out, o_serial_result_oe,
  input wire logic o_serial_clock_out, o_serial_clock_oe
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  localparam int T0 = MCLK_DIV - 1;
  localparam int T1 = MCLK_DIV + 1;
  localparam int T2 = 2 * MCLK_DIV + 4;
  localparam int T3 = 3 * MCLK_DIV + 4;
  wire logic m = i_serial_mode_select;
  wire logic rn = o_result_ready_n;
  wire logic oe = o_serial_result_oe;
  wire logic ck = o_serial_clock_out;
  logic [15:0] hi;
  // A counter keeps the high phase check free of long repetitions.
  always_ff @(posedge i_clock or negedge i_arst_n)
    if (!i_arst_n) hi <= '0;
    else hi <= ck ? hi + 16'h1 : '0;
  AST_CS_ACCESS: assert property ($fell(i_chip_select_n) && !rn && !oe
    && m |-> ##[1:T2] oe) else $error("Select access late.");
  AST_READY_ACCESS: assert property ($fell(rn) && !i_chip_select_n && m
    |-> ##[0:T3] oe) else $error("Ready access late.");
  AST_CLK_DELAY: assert property ($rose(oe) && m
    |-> !ck ##[T0:T1] $rose(ck)) else $error("Clock start off.");
  AST_CLK_HIGH: assert property ($fell(ck) |-> hi == MCLK_DIV)
    else $error("High phase length off.");
  AST_DATA_EDGE: assert property (m && oe && $past(oe)
    && $changed(o_serial_result_out) |-> $fell(ck))
    else $error("Data moved off a clock fall.");
  AST_EARLY_FLOAT: assert property ($rose(i_chip_select_n)
    |-> ##[0:T3] !oe && !o_serial_clock_oe) else $error("No float.");
  AST_GAP_BLOCK: assert property ($rose(oe) |-> !rn)
    else $error("Shift began while ready high.");
  AST_READY_FALL: assert property (i_result_valid && rn && !oe
    && !o_serial_clock_oe |-> ##[1:T3] !rn) else $error("Ready late.");
  AST_NO_CLK_HOST: assert property (!m |-> !o_serial_clock_oe)
    else $error("Clock driven in host mode.");
endmodule // arsp_port_monitor
bind arsp_port arsp_port_monitor #(.MCLK_DIV(MCLK_DIV), .WORD_BITS(WORD_BITS))
  mon (.i_clock, .i_arst_n, .i_result_valid, .i_result_word,
  .i_serial_mode_select, .i_chip_select_n, .i_serial_clock_in,
  .o_result_ready_n, .o_serial_result_out, .o_serial_result_oe,
  .o_serial_clock_out, .o_serial_clock_oe);
`default_nettype wire

// file: dv/arsp_host_model.sv
// Host shift register model: selects the port, clocks it, captures words.
// Assumes a 40 ns master tick and an 80 ns host serial clock.
`default_nettype none
module arsp_host_model (
  input  wire logic data, data_oe, sclk_out,
  output var  logic cs_n, sclk_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last;
  // A released line shows the inverse of its last bit, never a stale one.
  wire logic line = data_oe ? data : ~last;
  always @(data or data_oe) if (data_oe) last = data;
  initial begin
    cs_n = 1'b1;
    sclk_in = 1'b0;
  end
  task automatic xfer(input bit self, input int stop,
                      output logic [19:0] w, output logic flt);
    w = '0;
    cs_n = 1'b0;
    if (!self) #280;
    for (int i = 0; i < 20 && i < stop; i++) begin
      if (self) begin
        @(posedge sclk_out) #5 w = {w[18:0], line};
      end else begin
        sclk_in = 1'b1;
        w = {w[18:0], line};
        #40 sclk_in = 1'b0;
        #40;
      end
    end
    if (stop < 20) cs_n = 1'b1;
    #150 flt = data_oe;
    cs_n = 1'b1;
  endtask
endmodule // arsp_host_model
`default_nettype wire

// file: dv/arsp_port_tb_top.sv
// Self-checking bench: result words out in both serial modes.
// Assumes a four-cycle master tick and the host model on the pins.
`default_nettype none
module arsp_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock, i_arst_n, i_result_valid, i_serial_mode_select;
  logic [19:0] i_result_word, got;
  logic flt;
  wire logic cs_n, sclk_in, rdy_n, sd, sd_oe, sc, sc_oe;
  int n_mismatch = 0, n_checks = 0;
  logic [20:0] rows [4] = '{21'h1a5c3f, 21'h180001, 21'h07fffe, 21'h0c0ff3};
  arsp_port #(.WORD_BITS(20), .MCLK_DIV(4)) dut (.i_clock(i_clock),
    .i_arst_n(i_arst_n), .i_result_valid(i_result_valid),
    .i_result_word(i_result_word), .i_serial_mode_select(i_serial_mode_select),
    .i_chip_select_n(cs_n), .i_serial_clock_in(sclk_in),
    .o_result_ready_n(rdy_n), .o_serial_result_out(sd),
    .o_serial_result_oe(sd_oe), .o_serial_clock_out(sc),
    .o_serial_clock_oe(sc_oe));
  arsp_host_model host (.data(sd), .data_oe(sd_oe), .sclk_out(sc),
    .cs_n(cs_n), .sclk_in(sclk_in));
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  task automatic chk(input string nm, input logic [19:0] s, e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Mode only changes with a new word, between frames.
  task automatic load(input logic m, input logic [19:0] w);
    @(posedge i_clock);
    i_serial_mode_select <= m;
    i_result_valid <= 1'b1;
    i_result_word <= w;
    @(posedge i_clock);
    i_result_valid <= 1'b0;
    for (int k = 0; k < 40 && rdy_n !== 1'b0; k++) @(negedge i_clock);
    chk("ready", 20'(rdy_n), 20'h0);
  endtask
  initial begin
    i_arst_n = 1'b0;
    i_result_valid = 1'b0;
    i_result_word = '0;
    i_serial_mode_select = 1'b1;
    repeat (3) @(posedge i_clock);
    i_arst_n <= 1'b1;
    @(negedge i_clock);
    chk("reset", 20'({rdy_n, sd_oe, sc_oe}), 20'h4);
    foreach (rows[i]) begin
      load(rows[i][20], rows[i][19:0]);
      host.xfer(rows[i][20], 20, got, flt);
      chk("word", got, rows[i][19:0]);
      chk("float", 20'({flt, sc_oe}), 20'h0);
      chk("sent", 20'(rdy_n), 20'h1);
    end
    host.cs_n = 1'b0;
    load(1'b1, 20'h3c0f1);
    host.xfer(1'b1, 20, got, flt);
    chk("held select", got, 20'h3c0f1);
    load(1'b1, 20'h96a5f);
    host.xfer(1'b1, 5, got, flt);
    chk("part word", 20'(got[4:0]), 20'h12);
    chk("part float", 20'({flt, sc_oe}), 20'h0);
    give_verdict;
  end
  initial begin
    #50us;
    n_mismatch++;
    give_verdict;
  end
endmodule // arsp_port_tb_top
`default_nettype wire
